// >>> design/gcp_map.svh
// sizes, codes and reset values of the command front end
`ifndef GCP_MAP_SVH
`define GCP_MAP_SVH

`define GCP_BUF_DEPTH     128
`define GCP_OBUF_DEPTH    32
`define GCP_ADDR_DEFAULT  5'h02
`define GCP_CH_SPACE      7'h20
`define GCP_CH_TAB        7'h09
`define GCP_CH_NULL       7'h00
`define GCP_CH_SEMI       7'h3B
`define GCP_CH_CR         7'h0D
`define GCP_CH_LF         7'h0A
`define GCP_CH_QUERY      7'h3F
`define GCP_CH_PLUS       7'h2B
`define GCP_CH_MINUS      7'h2D
`define GCP_CH_POINT      7'h2E
`define GCP_CH_EXP        7'h45
`define GCP_FMT_INT       2'h0
`define GCP_FMT_REAL      2'h1
`define GCP_FMT_EXP       2'h2

`endif

// >>> design/gcp_pkg.sv
// types shared by the command front end
package gcp_pkg;

	typedef enum logic [3:0]
	{
		ST_COLLECT = 4'h1,
		ST_HEADER  = 4'h2,
		ST_PARAM   = 4'h4,
		ST_EXEC    = 4'h8
	} gcp_state_e;

	typedef logic [6:0] gcp_char_t;

endpackage

// >>> design/gcp_num.sv
// numeric parameter accumulator: sign, digits, point and exponent
`timescale 1ns/1ps
`include "gcp_map.svh"

module gcp_num
(
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        clr,
	input  wire logic        feed,
	input  wire logic [6:0]  ch,
	output logic             neg,
	output logic [31:0]      mant,
	output logic [3:0]       frac_digits,
	output logic             exp_neg,
	output logic [6:0]       exp_val,
	output logic             has_point,
	output logic             has_exp,
	output logic             has_digit,
	output logic             bad
);

	logic        any_seen;
	logic        exp_seen;
	wire logic   is_digit   = (ch >= 7'h30) && (ch <= 7'h39);
	wire logic   [3:0] dval = ch[3:0];
	wire logic   [31:0] next_mant = 32'(mant * 32'hA) + {28'h0, dval};
	wire logic   [6:0]  next_exp  = 7'(exp_val * 7'hA) + {3'h0, dval};

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			neg <= 1'b0; mant <= 32'h0; frac_digits <= 4'h0; exp_neg <= 1'b0;
			exp_val <= 7'h0; has_point <= 1'b0; has_exp <= 1'b0; has_digit <= 1'b0;
			bad <= 1'b0; any_seen <= 1'b0; exp_seen <= 1'b0;
		end
		else if (clr)
		begin
			// no sign means positive, missing exponent means zero
			neg <= 1'b0; mant <= 32'h0; frac_digits <= 4'h0; exp_neg <= 1'b0;
			exp_val <= 7'h0; has_point <= 1'b0; has_exp <= 1'b0; has_digit <= 1'b0;
			bad <= 1'b0; any_seen <= 1'b0; exp_seen <= 1'b0;
		end
		else if (feed)
		begin
			if (!has_exp)
			begin
				any_seen <= 1'b1;
				if (is_digit)
				begin
					// leading zeroes add nothing to the accumulated value
					mant <= next_mant;
					has_digit <= 1'b1;
					if (has_point && frac_digits != 4'hF)
						frac_digits <= frac_digits + 4'h1;
				end
				else if ((ch == `GCP_CH_PLUS || ch == `GCP_CH_MINUS) && !any_seen)
					neg <= (ch == `GCP_CH_MINUS);
				else if (ch == `GCP_CH_POINT && !has_point)
					has_point <= 1'b1;
				else if (ch == `GCP_CH_EXP && has_digit)
					has_exp <= 1'b1;
				else
					bad <= 1'b1;
			end
			else
			begin
				if (is_digit)
				begin
					exp_val <= next_exp;
					exp_seen <= 1'b1;
				end
				else if ((ch == `GCP_CH_PLUS || ch == `GCP_CH_MINUS) && !exp_seen)
				begin
					exp_neg <= (ch == `GCP_CH_MINUS);
					exp_seen <= 1'b1;
				end
				else
					bad <= 1'b1;
			end
		end
	end

endmodule

// >>> design/gcp_tx.sv
// output buffer and talker byte sender with response terminator
`timescale 1ns/1ps
`include "gcp_map.svh"

module gcp_tx
(
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        clr,
	input  wire logic        resp_wr,
	input  wire logic [7:0]  resp_byte,
	input  wire logic        resp_done,
	input  wire logic        talk,
	input  wire logic        delim_crlf,
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	output logic             tx_eoi,
	input  wire logic        tx_ready,
	output logic             resp_ready
);

	logic [6:0] obuf [`GCP_OBUF_DEPTH];
	logic [5:0] wcnt;
	logic [5:0] rcnt;
	logic [1:0] term_idx;

	function automatic logic [6:0] to_upper(input logic [6:0] c);
		to_upper = (c >= 7'h61 && c <= 7'h7A) ? (c - 7'h20) : c;
	endfunction

	wire logic in_data  = (rcnt != wcnt);
	wire logic last_cr  = !in_data && term_idx == 2'h0 && !delim_crlf;
	wire logic last_lf  = !in_data && term_idx == 2'h1;
	wire logic finished = !in_data && (term_idx == 2'h2 || (term_idx == 2'h1 && !delim_crlf));
	wire logic [6:0] cur_ch = in_data ? obuf[rcnt[4:0]] :
		(term_idx == 2'h0 ? `GCP_CH_CR : `GCP_CH_LF);

	assign tx_valid = talk && resp_ready && !finished;
	assign tx_data  = {1'b0, cur_ch};
	assign tx_eoi   = last_cr || last_lf;
	wire logic take = tx_valid && tx_ready;

	always_ff @(posedge core_clk)
	begin
		if (resp_wr && wcnt != 6'(`GCP_OBUF_DEPTH) && !resp_ready)
			obuf[wcnt[4:0]] <= to_upper(resp_byte[6:0]);
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wcnt <= 6'h0; rcnt <= 6'h0; term_idx <= 2'h0; resp_ready <= 1'b0;
		end
		else if (clr)
		begin
			// a new query throws the older answer away
			wcnt <= 6'h0; rcnt <= 6'h0; term_idx <= 2'h0; resp_ready <= 1'b0;
		end
		else
		begin
			if (resp_wr && wcnt != 6'(`GCP_OBUF_DEPTH) && !resp_ready)
				wcnt <= wcnt + 6'h1;
			if (resp_done)
				resp_ready <= 1'b1;
			if (take && in_data)
				rcnt <= rcnt + 6'h1;
			else if (take)
				term_idx <= term_idx + 2'h1;
			if (resp_ready && finished)
			begin
				wcnt <= 6'h0; rcnt <= 6'h0; term_idx <= 2'h0; resp_ready <= 1'b0;
			end
		end
	end

endmodule

// >>> design/gcp_top.sv
// remote command front end: listener buffer, parser, interface messages
// What this block does
// - only the low seven bits of each received byte count
// - lower-case letters are handled exactly like upper-case ones
// - space, tab, null and semicolon are dropped, never stored
// - response bytes are seven-bit with letters forced to upper case
// - bus address is panel-set, held in a register here, defaults to two
// - CR, LF, EOI or any mix ends a received string
// - responses end in CR or CR LF, EOI on last byte, CR LF default
// - interface clear drops talk and listen addressing
// - device clear empties buffers, clears errors and service request, keeps settings
// - lockout disables the local key; go-to-local returns to local mode
// - codes wait in the buffer until a terminator, then run in order
// - buffer holds 128 characters; separators and terminators take none
// - more than 128 stored characters flags overflow and runs nothing
// - an illegal header or parameter clears the buffer, skipping the rest
// - after a string is run the buffer clears, ready for more
// - a missing sign means positive; leading zeroes are ignored
// - integer parameters take no point; point sits after last digit
// - real parameters need a point, fraction digits optional
// - a missing exponent counts as zero and the value as real
// - a query loads its setting into the output buffer, sent when talking
// - only the latest query is kept, earlier ones are dropped
`timescale 1ns/1ps
`include "gcp_map.svh"

module gcp_top
(
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// addressing and interface messages, one-cycle pulses except ren, which is a level
	input  wire logic        addr_listen,
	input  wire logic        addr_talk,
	input  wire logic        unlisten,
	input  wire logic        untalk,
	input  wire logic        ifc,
	input  wire logic        dev_clear,
	input  wire logic        llo,
	input  wire logic        gtl,
	input  wire logic        ren,
	// front panel
	input  wire logic        panel_addr_wr,
	input  wire logic [4:0]  panel_addr,
	input  wire logic        panel_delim_wr,
	input  wire logic        panel_delim_crlf,
	// received bytes
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_eoi,
	output logic             rx_ready,
	// decoded commands
	output logic             cmd_valid,
	output logic [20:0]      cmd_header,
	input  wire logic [1:0]  cmd_fmt,
	output logic             cmd_neg,
	output logic [31:0]      cmd_mant,
	output logic [3:0]       cmd_frac,
	output logic             cmd_exp_neg,
	output logic [6:0]       cmd_exp,
	output logic             query_valid,
	output logic [20:0]      query_header,
	input  wire logic        resp_wr,
	input  wire logic [7:0]  resp_byte,
	input  wire logic        resp_done,
	// talker bytes
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	output logic             tx_eoi,
	input  wire logic        tx_ready,
	// status
	output logic [4:0]       bus_addr,
	output logic             delim_crlf,
	output logic             listening,
	output logic             talking,
	output logic             remote,
	output logic             local_key_en,
	output logic             overflow,
	output logic             syntax_err,
	output logic             srq_clear,
	output logic             resp_ready
);

	////////////////////////////////////////////////////////////////////////////
	// receive filter

	function automatic logic is_alpha(input logic [6:0] c);
		is_alpha = (c >= 7'h41 && c <= 7'h5A);
	endfunction

	gcp_pkg::gcp_state_e state;
	logic [6:0]  ibuf [`GCP_BUF_DEPTH];
	logic [7:0]  wcnt;
	logic [7:0]  rptr;
	logic        drop_rest;
	logic [1:0]  hcnt;
	logic        qry;
	logic        num_clr;
	logic        num_feed;

	wire logic [6:0] rx_ch    = rx_data[6:0];
	wire logic [6:0] rx_up    = (rx_ch >= 7'h61 && rx_ch <= 7'h7A) ? (rx_ch - 7'h20) : rx_ch;
	wire logic       rx_skip  = rx_ch == `GCP_CH_SPACE || rx_ch == `GCP_CH_TAB ||
		rx_ch == `GCP_CH_NULL || rx_ch == `GCP_CH_SEMI;
	wire logic       rx_term  = rx_ch == `GCP_CH_CR || rx_ch == `GCP_CH_LF;
	wire logic       rx_take  = rx_valid && rx_ready;
	wire logic       rx_store = rx_take && !rx_skip && !rx_term && !drop_rest;
	wire logic       buf_full = wcnt == 8'(`GCP_BUF_DEPTH);
	wire logic       rx_end   = rx_take && (rx_term || rx_eoi);

	assign rx_ready = listening && state == gcp_pkg::ST_COLLECT;

	////////////////////////////////////////////////////////////////////////////
	// parser datapath

	wire logic [6:0] cur_ch   = ibuf[rptr[6:0]];
	wire logic [7:0] prev_ptr = rptr - 8'h1;
	// the fed character sits one behind rptr, which moved on with the feed strobe
	wire logic [6:0] feed_ch  = ibuf[prev_ptr[6:0]];
	wire logic       at_end   = rptr == wcnt;
	logic            n_neg;
	logic [31:0]     n_mant;
	logic [3:0]      n_frac;
	logic            n_eneg;
	logic [6:0]      n_exp;
	logic            n_point;
	logic            n_hexp;
	logic            n_digit;
	logic            n_bad;

	wire logic fmt_ok = (cmd_fmt == `GCP_FMT_INT)  ? (!n_point && !n_hexp) :
		(cmd_fmt == `GCP_FMT_REAL) ? (n_point && !n_hexp) :
		(cmd_fmt == `GCP_FMT_EXP)  ? n_point : 1'b0;
	wire logic param_ok  = n_digit && !n_bad && fmt_ok;
	wire logic param_end = at_end || cur_ch == `GCP_CH_QUERY ||
		(is_alpha(cur_ch) && !(cur_ch == `GCP_CH_EXP && !n_hexp));

	gcp_num u_num
	(
		.core_clk    (core_clk),
		.arst_n      (arst_n),
		.clr         (num_clr),
		.feed        (num_feed),
		.ch          (feed_ch),
		.neg         (n_neg),
		.mant        (n_mant),
		.frac_digits (n_frac),
		.exp_neg     (n_eneg),
		.exp_val     (n_exp),
		.has_point   (n_point),
		.has_exp     (n_hexp),
		.has_digit   (n_digit),
		.bad         (n_bad)
	);

	////////////////////////////////////////////////////////////////////////////
	// buffer fill and parse sequence

	always_ff @(posedge core_clk)
	begin
		if (rx_store && !buf_full)
			ibuf[wcnt[6:0]] <= rx_up;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= gcp_pkg::ST_COLLECT; wcnt <= 8'h0; rptr <= 8'h0; drop_rest <= 1'b0;
			hcnt <= 2'h0; qry <= 1'b0; cmd_header <= 21'h0; cmd_valid <= 1'b0;
			query_valid <= 1'b0; query_header <= 21'h0; overflow <= 1'b0; syntax_err <= 1'b0;
			num_clr <= 1'b0; num_feed <= 1'b0; cmd_neg <= 1'b0; cmd_mant <= 32'h0;
			cmd_frac <= 4'h0; cmd_exp_neg <= 1'b0; cmd_exp <= 7'h0;
		end
		else
		begin
			cmd_valid <= 1'b0;
			query_valid <= 1'b0;
			num_clr <= 1'b0;
			num_feed <= 1'b0;
			if (dev_clear)
			begin
				state <= gcp_pkg::ST_COLLECT; wcnt <= 8'h0; drop_rest <= 1'b0;
				overflow <= 1'b0; syntax_err <= 1'b0;
			end
			else
			case (state)
			gcp_pkg::ST_COLLECT:
			begin
				if (rx_store && buf_full)
				begin
					overflow <= 1'b1; wcnt <= 8'h0; drop_rest <= 1'b1;
				end
				else if (rx_store)
					wcnt <= wcnt + 8'h1;
				if (rx_end)
				begin
					drop_rest <= 1'b0;
					rptr <= 8'h0; hcnt <= 2'h0; qry <= 1'b0;
					if (!drop_rest && !(rx_store && buf_full) && (wcnt != 8'h0 || rx_store))
						state <= gcp_pkg::ST_HEADER;
					else
						wcnt <= 8'h0;
				end
			end
			gcp_pkg::ST_HEADER:
			begin
				if (hcnt == 2'h3 && qry)
				begin
					query_valid <= 1'b1; query_header <= cmd_header; hcnt <= 2'h0; qry <= 1'b0;
				end
				else if (hcnt == 2'h3)
				begin
					num_clr <= 1'b1; state <= gcp_pkg::ST_PARAM;
				end
				else if (at_end && hcnt == 2'h0 && !qry)
				begin
					wcnt <= 8'h0; state <= gcp_pkg::ST_COLLECT;
				end
				else if (!at_end && hcnt == 2'h0 && !qry && cur_ch == `GCP_CH_QUERY)
				begin
					qry <= 1'b1; rptr <= rptr + 8'h1;
				end
				else if (!at_end && is_alpha(cur_ch))
				begin
					cmd_header <= {cmd_header[13:0], cur_ch}; hcnt <= hcnt + 2'h1; rptr <= rptr + 8'h1;
				end
				else
				begin
					syntax_err <= 1'b1; wcnt <= 8'h0; state <= gcp_pkg::ST_COLLECT;
				end
			end
			gcp_pkg::ST_PARAM:
			begin
				if (num_feed || num_clr)
					;
				else if (param_end)
					state <= gcp_pkg::ST_EXEC;
				else
				begin
					num_feed <= 1'b1; rptr <= rptr + 8'h1;
				end
			end
			gcp_pkg::ST_EXEC:
			begin
				if (param_ok)
				begin
					cmd_valid <= 1'b1; cmd_neg <= n_neg; cmd_mant <= n_mant; cmd_frac <= n_frac;
					cmd_exp_neg <= n_eneg; cmd_exp <= n_exp; hcnt <= 2'h0;
					state <= gcp_pkg::ST_HEADER;
				end
				else
				begin
					syntax_err <= 1'b1; wcnt <= 8'h0; state <= gcp_pkg::ST_COLLECT;
				end
			end
			default:
				state <= gcp_pkg::ST_COLLECT;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// addressing, remote/local and panel settings

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			listening <= 1'b0; talking <= 1'b0; remote <= 1'b0; local_key_en <= 1'b1;
			bus_addr <= `GCP_ADDR_DEFAULT; delim_crlf <= 1'b1; srq_clear <= 1'b0;
		end
		else
		begin
			srq_clear <= dev_clear;
			if (ifc)
			begin
				listening <= 1'b0; talking <= 1'b0;
			end
			else
			begin
				if (addr_listen)
				begin
					listening <= 1'b1; talking <= 1'b0;
				end
				else if (addr_talk)
				begin
					talking <= 1'b1; listening <= 1'b0;
				end
				if (unlisten)
					listening <= 1'b0;
				if (untalk)
					talking <= 1'b0;
			end
			if (!ren)
				remote <= 1'b0;
			else if (gtl)
				remote <= 1'b0;
			else if (addr_listen)
				remote <= 1'b1;
			if (!ren)
				local_key_en <= 1'b1;
			else if (llo)
				local_key_en <= 1'b0;
			if (panel_addr_wr)
				bus_addr <= panel_addr;
			if (panel_delim_wr)
				delim_crlf <= panel_delim_crlf;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// response path

	gcp_tx u_tx
	(
		.core_clk   (core_clk),
		.arst_n     (arst_n),
		.clr        (dev_clear || query_valid),
		.resp_wr    (resp_wr),
		.resp_byte  (resp_byte),
		.resp_done  (resp_done),
		.talk       (talking),
		.delim_crlf (delim_crlf),
		.tx_valid   (tx_valid),
		.tx_data    (tx_data),
		.tx_eoi     (tx_eoi),
		.tx_ready   (tx_ready),
		.resp_ready (resp_ready)
	);

endmodule

// >>> bench/gcp_chk_sva.sv
// port assertions for the command front end
`timescale 1ns/1ps
module gcp_chk
(
	input wire logic       core_clk,
	input wire logic       arst_n,
	input wire logic       ifc,
	input wire logic       dev_clear,
	input wire logic       llo,
	input wire logic       gtl,
	input wire logic       ren,
	input wire logic       panel_addr_wr,
	input wire logic [4:0] panel_addr,
	input wire logic       rx_ready,
	input wire logic       cmd_valid,
	input wire logic       query_valid,
	input wire logic       tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic       tx_eoi,
	input wire logic       listening,
	input wire logic       talking,
	input wire logic       remote,
	input wire logic       local_key_en,
	input wire logic       overflow,
	input wire logic       syntax_err,
	input wire logic       srq_clear,
	input wire logic [4:0] bus_addr,
	input wire logic       delim_crlf
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence s_dcl;
		##1 srq_clear && !overflow && !syntax_err ##1 !srq_clear;
	endsequence
	property p_dcl; dev_clear |-> s_dcl; endproperty
	property p_ifc; ifc |=> !listening && !talking; endproperty
	property p_llo; llo && ren |=> !local_key_en; endproperty
	property p_gtl; gtl |=> !remote; endproperty
	property p_ren; !ren && !llo |=> local_key_en && !remote; endproperty
	property p_tx7; tx_valid |-> !tx_data[7] && !(tx_data inside {[8'h61:8'h7A]}); endproperty
	property p_eoi; tx_valid && tx_eoi |-> tx_data == (delim_crlf ? 8'h0A : 8'h0D); endproperty
	property p_hold; cmd_valid || query_valid |-> !rx_ready; endproperty
	property p_addr; panel_addr_wr |=> bus_addr == $past(panel_addr); endproperty
	property p_ovf; overflow && !dev_clear |=> overflow; endproperty
	a_dcl: assert property (p_dcl) else $error("device clear left state");
	a_ifc: assert property (p_ifc) else $error("addressing kept after clear");
	a_llo: assert property (p_llo) else $error("local key still enabled");
	a_gtl: assert property (p_gtl) else $error("still remote after go-to-local");
	a_ren: assert property (p_ren) else $error("remote kept without enable");
	a_tx7: assert property (p_tx7) else $error("talker byte not upper-case ascii");
	a_eoi: assert property (p_eoi) else $error("end flag on wrong byte");
	a_hold: assert property (p_hold) else $error("decode while receiving");
	a_addr: assert property (p_addr) else $error("bus address not taken");
	a_ovf: assert property (p_ovf) else $error("overflow flag lost");
endmodule
bind gcp_top gcp_chk i_chk (.core_clk, .arst_n, .ifc, .dev_clear, .llo, .gtl, .ren, .panel_addr_wr,
	.panel_addr, .rx_ready, .cmd_valid, .query_valid, .tx_valid, .tx_data, .tx_eoi, .listening, .talking,
	.remote, .local_key_en, .overflow, .syntax_err, .srq_clear, .bus_addr, .delim_crlf);

// >>> bench/gcp_ctl_model.sv
// bus controller model: sends program bytes, takes talker bytes with stalls
`timescale 1ns/1ps
module gcp_ctl_model
(
	input  wire logic       core_clk,
	input  wire logic       rx_ready,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_eoi,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_eoi,
	output logic            tx_ready
);
	logic [8:0] got[$];
	logic [1:0] cnt = 2'h0;
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_eoi = 1'b0;
	end
	// talker bytes accepted three cycles in four
	assign tx_ready = cnt != 2'h0;
	always @(posedge core_clk)
	begin
		cnt <= cnt + 2'h1;
		if (tx_valid === 1'b1 && tx_ready)
			got.push_back({tx_eoi, tx_data});
	end
	// byte held until the edge that finds rx_ready high
	task put(input logic [7:0] b, input logic e);
		rx_valid <= 1'b1;
		rx_data <= b;
		rx_eoi <= e;
		@(posedge core_clk);
		while (rx_ready !== 1'b1)
			@(posedge core_clk);
	endtask
	// released data lines show the inverse of the last byte
	task idle();
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
		rx_eoi <= 1'b0;
	endtask
endmodule

// >>> bench/gcp_command_parser_tb_top.sv
// self-checking bench of the command front end
`timescale 1ns/1ps
module gcp_command_parser_tb_top;
	localparam logic [20:0] H_FRQ = {7'h46, 7'h52, 7'h51};
	localparam logic [20:0] H_AMP = {7'h41, 7'h4D, 7'h50};
	localparam logic [20:0] H_STM = {7'h53, 7'h54, 7'h4D};
	logic        core_clk, arst_n, ren, panel_addr_wr, panel_delim_wr, panel_delim_crlf, resp_wr, resp_done;
	logic        rx_valid, rx_eoi, rx_ready, cmd_valid, query_valid, tx_valid, tx_eoi, tx_ready, hi7;
	logic        cmd_neg, cmd_exp_neg, delim_crlf, listening, talking, remote, local_key_en;
	logic        overflow, syntax_err, srq_clear, resp_ready;
	logic [7:0]  pv, rx_data, resp_byte, tx_data;
	logic [4:0]  panel_addr, bus_addr;
	logic [20:0] cmd_header, query_header;
	logic [1:0]  cmd_fmt;
	logic [31:0] cmd_mant;
	logic [3:0]  cmd_frac;
	logic [6:0]  cmd_exp;
	logic [65:0] cq[$];
	logic [65:0] ex[4];
	int          num_errors = 0, n_compared = 0, n_qry = 0;
	gcp_top i_dut (.core_clk, .arst_n, .addr_listen(pv[0]), .addr_talk(pv[1]), .unlisten(pv[2]),
		.untalk(pv[3]), .ifc(pv[4]), .dev_clear(pv[5]), .llo(pv[6]), .gtl(pv[7]), .ren, .panel_addr_wr,
		.panel_addr, .panel_delim_wr, .panel_delim_crlf, .rx_valid, .rx_data, .rx_eoi, .rx_ready, .cmd_valid,
		.cmd_header, .cmd_fmt, .cmd_neg, .cmd_mant, .cmd_frac, .cmd_exp_neg, .cmd_exp, .query_valid,
		.query_header, .resp_wr, .resp_byte, .resp_done, .tx_valid, .tx_data, .tx_eoi, .tx_ready, .bus_addr,
		.delim_crlf, .listening, .talking, .remote, .local_key_en, .overflow, .syntax_err, .srq_clear,
		.resp_ready);
	gcp_ctl_model i_ctl (.core_clk, .rx_ready, .tx_valid, .tx_data, .tx_eoi, .rx_valid, .rx_data, .rx_eoi,
		.tx_ready);
	// format table of the command executor
	assign cmd_fmt = cmd_header == H_FRQ ? 2'h1 : cmd_header == H_AMP ? 2'h0 : cmd_header == H_STM ? 2'h2 : 2'h3;
	always @(posedge core_clk)
	begin
		if (cmd_valid === 1'b1)
			cq.push_back({cmd_header, cmd_neg, cmd_frac, cmd_exp_neg, cmd_exp, cmd_mant});
		if (query_valid === 1'b1)
			n_qry <= n_qry + 1;
	end
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////////////////////////////
	task check(input logic [65:0] seen, input logic [65:0] want);
		n_compared++;
		if (seen !== want)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	task wrap_up();
		if (num_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task pulse(input int i);
		pv[i] <= 1'b1;
		@(posedge core_clk);
		pv <= 8'h00;
		@(posedge core_clk);
	endtask
	// send a string, then wait for the parser to come back
	task line(input string s, input logic e);
		for (int i = 0; i < s.len(); i++)
			i_ctl.put(s[i] ^ {hi7, 7'h00}, e && i == s.len() - 1);
		i_ctl.idle();
		repeat (2) @(posedge core_clk);
		for (int k = 0; k < 3000 && rx_ready !== 1'b1; k++)
			@(posedge core_clk);
		check(66'(rx_ready), 66'h1);
	endtask
	////////////////////////////////////////////////////////////////////////////////////////////////
	task t_reset();
		check(66'(bus_addr), 66'h2);
		check(66'(delim_crlf), 66'h1);
		panel_addr <= 5'h0B;
		panel_addr_wr <= 1'b1;
		@(posedge core_clk);
		panel_addr_wr <= 1'b0;
		@(posedge core_clk);
		check(66'(bus_addr), 66'hB);
		pulse(0);
	endtask
	task t_set();
		cq.delete();
		hi7 = 1'b1;
		line("frq +01.5;AMP-500\tstm1.8\n", 1'b0);
		hi7 = 1'b0;
		line("Stm-2.5E-3", 1'b1);
		ex[0] = {H_FRQ, 1'b0, 4'h1, 1'b0, 7'h00, 32'h0000000F};
		ex[1] = {H_AMP, 1'b1, 4'h0, 1'b0, 7'h00, 32'h000001F4};
		ex[2] = {H_STM, 1'b0, 4'h1, 1'b0, 7'h00, 32'h00000012};
		ex[3] = {H_STM, 1'b1, 4'h1, 1'b1, 7'h03, 32'h00000019};
		check(66'(cq.size()), 66'h4);
		for (int i = 0; i < 4; i++)
			check(cq[i], ex[i]);
	endtask
	task t_buf();
		string s;
		s = "";
		for (int i = 0; i < 32; i++)
			s = {s, "amp7"};
		cq.delete();
		line({s, "\n"}, 1'b0);
		check(66'(cq.size()), 66'h20);
		check(66'(overflow), 66'h0);
		cq.delete();
		line({s, "a\n"}, 1'b0);
		check(66'(cq.size()), 66'h0);
		check(66'(overflow), 66'h1);
		pulse(5);
		check(66'(overflow), 66'h0);
	endtask
	task t_err();
		cq.delete();
		line("amp2frq5xyz amp3\n", 1'b0);
		check(66'(cq.size()), 66'h1);
		check(66'(syntax_err), 66'h1);
		line("amp4\n", 1'b0);
		check(66'(cq.size()), 66'h2);
		pulse(5);
		check(66'(syntax_err), 66'h0);
	endtask
	task t_qry();
		string s, r, w;
		int q0;
		r = "frq 1.5";
		for (int d = 1; d >= 0; d--)
		begin
			panel_delim_crlf <= d[0];
			panel_delim_wr <= 1'b1;
			@(posedge core_clk);
			panel_delim_wr <= 1'b0;
			pulse(0);
			q0 = n_qry;
			if (d == 1)
				s = "?frq\n";
			else
				s = "?amp?frq\n";
			line(s, 1'b0);
			check(66'(n_qry - q0), 66'(2 - d));
			check(66'(query_header), 66'(H_FRQ));
			for (int i = 0; i < r.len(); i++)
			begin
				resp_wr <= 1'b1;
				resp_byte <= r[i];
				@(posedge core_clk);
			end
			resp_wr <= 1'b0;
			resp_done <= 1'b1;
			@(posedge core_clk);
			resp_done <= 1'b0;
			i_ctl.got.delete();
			pulse(1);
			check(66'(resp_ready), 66'h1);
			w = d == 1 ? "FRQ 1.5\r\n" : "FRQ 1.5\r ";
			w = w.substr(0, 7 + d);
			for (int k = 0; k < 300 && i_ctl.got.size() < w.len(); k++)
				@(posedge core_clk);
			for (int i = 0; i < w.len(); i++)
				check(66'(i_ctl.got[i]), 66'({i == w.len() - 1, w[i]}));
			pulse(3);
			check(66'(resp_ready), 66'h0);
		end
	endtask
	task t_ifc();
		pulse(0);
		pulse(4);
		check(66'({listening, talking}), 66'h0);
		pulse(0);
		pulse(6);
		check(66'(local_key_en), 66'h0);
		pulse(7);
		check(66'(remote), 66'h0);
		ren <= 1'b0;
		repeat (2) @(posedge core_clk);
		check(66'(local_key_en), 66'h1);
		ren <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		arst_n = 1'b0;
		pv = 8'h00;
		ren = 1'b1;
		{panel_addr_wr, panel_delim_wr, panel_delim_crlf, resp_wr, resp_done, hi7} = 6'h00;
		panel_addr = 5'h00;
		resp_byte = 8'h00;
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_set();
		t_buf();
		t_err();
		t_qry();
		t_ifc();
		wrap_up();
	end
	initial
	begin
		#(5_000_000);
		num_errors++;
		wrap_up();
	end
endmodule
